// ===== verilog/fractional_divider_config.sv
// configuration register and control outputs of one fractional output divider
`timescale 1ns/100ps
`default_nettype none
`include "frac_div_defs.svh"

module fractional_divider_config
(
  // clock and reset
  input  wire logic                       REF_CLK_I,
  input  wire logic                       RST_B_I,
  // byte register port from the serial interface
  input  wire logic                       REG_WR_I,
  input  wire logic                       REG_RD_I,
  input  wire frac_div_pkg::byte_addr_t   REG_ADDR_I,
  input  wire frac_div_pkg::byte_t        REG_WDATA_I,
  output logic [7:0]                      REG_RDATA_O,
  // divider controls
  output logic                            FRAC_DIV_POWER_DOWN_O,
  output logic                            FRAC_DIV_DISABLE_O,
  output logic                            FRAC_DIV_RESET_O,
  output logic                            SIGMA_DELTA_ACC_RESET_O,
  output logic                            SLOW_FREQ_EN_O,
  // divider ratios
  output logic [33:0]                     FRAC_O,
  output logic [8:0]                      FIRST_STAGE_RATIO_O,
  output logic [17:0]                     SECOND_STAGE_DIV_O,
  output logic                            SECOND_STAGE_BYPASS_O,
  output logic                            RATIO_COMMIT_O
);
  import frac_div_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // decode

  cfg_word_t    shadow;
  frac_t        act_frac;
  first_ratio_t act_first;
  logic         slow_freq_en;
  logic         commit;
  logic [7:0]   byte_hit;
  logic         phase_hi_hit;
  logic         cfg_sel;
  byte_t        cfg_byte;
  byte_t        phase_hi_byte;
  byte_t        next_rdata;
  half_ratio_t  half_ratio;

  assign commit        = REG_WR_I && (REG_ADDR_I == `FDC_ADDR_COMMIT);
  assign phase_hi_hit  = REG_WR_I && (REG_ADDR_I == `FDC_ADDR_PHASE_HI);
  assign cfg_sel       = (REG_ADDR_I < 4'(`FDC_CFG_BYTES));
  assign cfg_byte      = shadow[{REG_ADDR_I[2:0], 3'b000} +: 8];
  assign phase_hi_byte = byte_t'({slow_freq_en, 5'h00});
  assign next_rdata    = cfg_sel ? cfg_byte :
                         (REG_ADDR_I == `FDC_ADDR_PHASE_HI) ? phase_hi_byte : 8'h00;
  assign half_ratio    = shadow[`FDC_HALF_MSB:`FDC_HALF_LSB];

  ////////////////////////////////////////////////////////////////////////////
  // software-visible shadow, one byte per generate entry

  genvar b;
  generate
    for (b = 0; b < `FDC_CFG_BYTES; b++)
    begin : g_byte
      assign byte_hit[b] = REG_WR_I && (REG_ADDR_I == 4'(b));
      always_ff @(posedge REF_CLK_I or negedge RST_B_I)
      begin
        if (!RST_B_I)
          shadow[8*b +: 8] <= 8'(`FDC_CFG_RESET >> (8*b));
        else if (byte_hit[b])
          shadow[8*b +: 8] <= REG_WDATA_I;
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // active ratio, loaded as one group on the commit byte

  // the commit byte carries fraction[33:30] itself, so it comes from the bus
  always_ff @(posedge REF_CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      act_frac  <= 34'h0_0000_0000;
      act_first <= `FDC_FIRST_RESET;
    end
    else if (commit)
    begin
      act_frac  <= {REG_WDATA_I[3:0], shadow[`FDC_FRAC_SHADOW_MSB:`FDC_FRAC_LSB]};
      act_first <= shadow[`FDC_FIRST_MSB:0];
    end
  end

  always_ff @(posedge REF_CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
      RATIO_COMMIT_O <= 1'b0;
    else
      RATIO_COMMIT_O <= commit;
  end

  ////////////////////////////////////////////////////////////////////////////
  // phase register: only the low-frequency enable lives here

  always_ff @(posedge REF_CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
      slow_freq_en <= 1'b0;
    else if (phase_hi_hit)
      slow_freq_en <= REG_WDATA_I[`FDC_SLOW_BIT_IN_HI];
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data, one cycle after the read strobe

  always_ff @(posedge REF_CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
      REG_RDATA_O <= 8'h00;
    else if (REG_RD_I)
      REG_RDATA_O <= next_rdata;
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs; controls act at once, the sequencing with reset is software's job

  assign FRAC_DIV_POWER_DOWN_O   = shadow[`FDC_BIT_PD];
  assign FRAC_DIV_DISABLE_O      = shadow[`FDC_BIT_DIS];
  assign FRAC_DIV_RESET_O        = shadow[`FDC_BIT_RST];
  assign SIGMA_DELTA_ACC_RESET_O = shadow[`FDC_BIT_ACC_RST];
  assign SLOW_FREQ_EN_O          = slow_freq_en;
  assign FRAC_O                  = act_frac;
  assign FIRST_STAGE_RATIO_O     = act_first;
  // second stage is outside the atomic group and follows its bytes directly
  assign SECOND_STAGE_DIV_O      = {half_ratio, 1'b0};
  assign SECOND_STAGE_BYPASS_O   = (half_ratio == 17'h0_0000);

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (!RST_B_I);

  sequence commit_write;
    REG_WR_I && (REG_ADDR_I == `FDC_ADDR_COMMIT);
  endsequence

  sequence no_commit;
    !(REG_WR_I && (REG_ADDR_I == `FDC_ADDR_COMMIT));
  endsequence

  a_pd_from_write: assert property (
    commit_write |=> FRAC_DIV_POWER_DOWN_O == $past(REG_WDATA_I[7]))
    else $error("power-down does not follow written bit 63");

  a_dis_from_write: assert property (
    commit_write |=> FRAC_DIV_DISABLE_O == $past(REG_WDATA_I[6]))
    else $error("disable does not follow written bit 62");

  a_rst_from_write: assert property (
    commit_write |=> FRAC_DIV_RESET_O == $past(REG_WDATA_I[5]))
    else $error("divider reset does not follow written bit 61");

  a_acc_rst_write: assert property (
    commit_write |=> SIGMA_DELTA_ACC_RESET_O == $past(REG_WDATA_I[4]))
    else $error("accumulator reset does not follow written bit 60");

  a_frac_commit_value: assert property (
    commit_write |=> FRAC_O[33:30] == $past(REG_WDATA_I[3:0])
                     && FRAC_O[29:0] == $past(shadow[55:26]))
    else $error("committed fraction differs from written bytes");

  a_commit_group_pulse: assert property (
    commit_write |=> RATIO_COMMIT_O && FIRST_STAGE_RATIO_O == $past(shadow[8:0]))
    else $error("first stage ratio not applied with commit");

  a_ratio_holds: assert property (
    no_commit |=> $stable(FRAC_O) && $stable(FIRST_STAGE_RATIO_O) && !RATIO_COMMIT_O)
    else $error("active ratio changed without commit write");

  a_second_twice: assert property (
    SECOND_STAGE_DIV_O[17:1] == shadow[25:9] && !SECOND_STAGE_DIV_O[0])
    else $error("second stage divide not twice the field");

  a_second_bypass: assert property (
    (REG_WR_I && REG_ADDR_I == 4'h1 && REG_WDATA_I[7:1] == 7'h00
     && shadow[25:16] == 10'h000) |=> SECOND_STAGE_BYPASS_O)
    else $error("zero second stage field not bypassed");

  a_first_reset_val: assert property (
    $rose(RST_B_I) |-> FIRST_STAGE_RATIO_O == `FDC_FIRST_RESET)
    else $error("first stage ratio not at reset value");

  a_slow_freq_write: assert property (
    (REG_WR_I && REG_ADDR_I == `FDC_ADDR_PHASE_HI)
      |=> SLOW_FREQ_EN_O == $past(REG_WDATA_I[5]) ##1 $stable(SLOW_FREQ_EN_O)
          || $past(REG_WR_I && REG_ADDR_I == `FDC_ADDR_PHASE_HI))
    else $error("low-frequency enable not taken from phase bit 13");

endmodule
`default_nettype wire

// ===== verilog/frac_div_defs.svh
// offsets, field positions and reset values of the fractional divider config
`ifndef FRAC_DIV_DEFS_SVH
`define FRAC_DIV_DEFS_SVH

`define FDC_CFG_BYTES      8
`define FDC_ADDR_COMMIT    4'h7
`define FDC_ADDR_PHASE_LO  4'h8
`define FDC_ADDR_PHASE_HI  4'h9
`define FDC_BIT_PD         63
`define FDC_BIT_DIS        62
`define FDC_BIT_RST        61
`define FDC_BIT_ACC_RST    60
`define FDC_FRAC_MSB       59
`define FDC_FRAC_LSB       26
`define FDC_FRAC_SHADOW_MSB 55
`define FDC_HALF_MSB       25
`define FDC_HALF_LSB       9
`define FDC_FIRST_MSB      8
`define FDC_FIRST_RESET    9'h064
`define FDC_CFG_RESET      64'h0000_0000_0000_0064
`define FDC_SLOW_BIT_IN_HI 5

`endif

// ===== verilog/frac_div_pkg.sv
// types shared by the fractional divider config block
package frac_div_pkg;
  typedef logic [63:0] cfg_word_t;
  typedef logic [33:0] frac_t;
  typedef logic [8:0]  first_ratio_t;
  typedef logic [16:0] half_ratio_t;
  typedef logic [17:0] second_div_t;
  typedef logic [3:0]  byte_addr_t;
  typedef logic [7:0]  byte_t;
endpackage

// ===== tb/testbench.sv
// self-checking bench for the fractional divider config block
`timescale 1ns/100ps
`default_nettype none
`include "frac_div_defs.svh"

module testbench;
  import frac_div_pkg::*;
  logic         clk = 1'b0;
  logic         rst_b = 1'b0;
  logic         wr = 1'b0;
  logic         rd = 1'b0;
  byte_addr_t   addr = 4'h0;
  byte_t        wdata = 8'h00;
  logic [7:0]   rdata;
  logic         pd, dis, drst, arst, slow, byp, commit;
  frac_t        frac;
  first_ratio_t first;
  second_div_t  second;
  // first stage ratio 0x050 keeps the stage output inside its legal band
  cfg_word_t    cfg = 64'h05A5_5A5A_C3C3_C050;
  byte_t        ctl [5] = '{8'hA3, 8'h2C, 8'h60, 8'h20, 8'h10};
  int           fails = 0;
  int           checked = 0;

  fractional_divider_config u_dut (.REF_CLK_I(clk), .RST_B_I(rst_b), .REG_WR_I(wr),
    .REG_RD_I(rd), .REG_ADDR_I(addr), .REG_WDATA_I(wdata), .REG_RDATA_O(rdata),
    .FRAC_DIV_POWER_DOWN_O(pd), .FRAC_DIV_DISABLE_O(dis), .FRAC_DIV_RESET_O(drst),
    .SIGMA_DELTA_ACC_RESET_O(arst), .SLOW_FREQ_EN_O(slow), .FRAC_O(frac),
    .FIRST_STAGE_RATIO_O(first), .SECOND_STAGE_DIV_O(second),
    .SECOND_STAGE_BYPASS_O(byp), .RATIO_COMMIT_O(commit));

  always #5 clk = ~clk;

  ////////////////////////////////////////////////////////////
  task automatic cmp(input string name, input logic [63:0] exp, input logic [63:0] got);
    checked++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value %s expected %0h seen %0h", name, exp, got);
    end
  endtask

  task automatic wr_byte(input byte_addr_t a, input byte_t d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask

  task automatic rd_byte(input byte_addr_t a, input byte_t exp);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    cmp("read data", exp, rdata);
  endtask

  // controls compared against the top nibble of the config word
  task automatic ctl_chk(input cfg_word_t c);
    cmp("power down", c[63], pd);
    cmp("disable", c[62], dis);
    cmp("divider reset", c[61], drst);
    cmp("accumulator reset", c[60], arst);
  endtask

  // latency of the pulse is bounded, not assumed
  task automatic commit_chk(input cfg_word_t c);
    int n;
    n = 0;
    while (commit !== 1'b1 && n < 3)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    cmp("commit pulse", 1, commit);
    cmp("fraction", c[59:26], frac);
    cmp("first ratio", c[8:0], first);
    @(posedge clk);
    #1;
    cmp("commit pulse end", 0, commit);
  endtask

  // outputs checked while reset is still held
  task automatic rst_cycle();
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (20) @(posedge clk);
    #1;
    ctl_chk(64'h0);
    cmp("fraction", 0, frac);
    cmp("first ratio", `FDC_FIRST_RESET, first);
    cmp("second div", 0, second);
    cmp("bypass", 1, byp);
    cmp("slow enable", 0, slow);
    cmp("commit pulse", 0, commit);
    @(posedge clk);
    rst_b <= 1'b1;
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////
  initial
  begin
    #100000;
    fails++;
    results();
  end

  initial
  begin
    rst_cycle();
    for (int i = 0; i < 7; i++)
      wr_byte(i[3:0], cfg[8*i+:8]);
    cmp("fraction", 0, frac);
    cmp("first ratio", `FDC_FIRST_RESET, first);
    cmp("second div", {cfg[25:9], 1'b0}, second);
    cmp("bypass", 0, byp);
    wr_byte(`FDC_ADDR_COMMIT, cfg[63:56]);
    commit_chk(cfg);
    for (int i = 0; i < 8; i++)
      rd_byte(i[3:0], cfg[8*i+:8]);
    // smallest legal second stage, with fraction low bits moved too
    cfg[25:9] = 17'h00002;
    cfg[31:26] = ~cfg[31:26];
    for (int i = 1; i < 4; i++)
      wr_byte(i[3:0], cfg[8*i+:8]);
    cmp("second div", 18'h00004, second);
    cmp("fraction", 34'h0, frac ^ 34'(64'h05A5_5A5A_C3C3_C1FF >> 26));
    cfg[25:9] = 17'h00000;
    for (int i = 1; i < 4; i++)
      wr_byte(i[3:0], cfg[8*i+:8]);
    cmp("bypass", 1, byp);
    cmp("second div", 0, second);
    // reset kept across the write that lifts power-down or disable
    foreach (ctl[k])
    begin
      cfg[63:56] = ctl[k];
      wr_byte(`FDC_ADDR_COMMIT, ctl[k]);
      ctl_chk(cfg);
      commit_chk(cfg);
    end
    wr_byte(4'h9, 8'hFF);
    cmp("slow enable", 1, slow);
    // slow first stage only once low-frequency enable is set; spreading needs zero low bits
    cfg[8:0] = 9'h0C8;
    cfg[31:26] = 6'h00;
    wr_byte(4'h0, cfg[7:0]);
    wr_byte(4'h3, cfg[31:24]);
    wr_byte(`FDC_ADDR_COMMIT, cfg[63:56]);
    commit_chk(cfg);
    rd_byte(4'h9, 8'h20);
    rd_byte(4'h8, 8'h00);
    wr_byte(4'hC, 8'hFF);
    rd_byte(4'hC, 8'h00);
    wr_byte(4'h9, 8'h00);
    cmp("slow enable", 0, slow);
    rst_cycle();
    rd_byte(4'h0, 8'h64);
    rd_byte(4'h7, 8'h00);
    results();
  end
endmodule
`default_nettype wire
